/* File: core/bfr_receiver.sv */
`timescale 1ns/10ps
`default_nettype none

module bfr_receiver #(
	parameter int unsigned ADC_W = 12,
	parameter int unsigned MARK_HZ = bfr_pkg::MARK_HZ,
	parameter int unsigned SPACE_HZ = bfr_pkg::SPACE_HZ,
	parameter int unsigned DEC_DIV = bfr_pkg::DEC_DIV,
	parameter int unsigned TIMEOUT_CYC = bfr_pkg::TIMEOUT_CYC
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic clk_en_i,
	// adc sample pins
	input wire logic [ADC_W-1:0] adc_data_i,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// front end and indicators
	output logic rx_path_en_o,
	output logic one_pkt_o,
	output logic zero_pkt_o
);

	// ----------------------------------------------------------------
	// constants
	// ----------------------------------------------------------------
	localparam int unsigned FB = bfr_pkg::FRAME_BITS;
	localparam int unsigned WL = bfr_pkg::WORD_LENGTH;
	localparam int unsigned NW = bfr_pkg::WORDS_PER_FRAME;
	localparam logic [31:0] MARK_INC =
		32'((64'(MARK_HZ) << 32) / 64'(bfr_pkg::SAMPLE_HZ));
	localparam logic [31:0] SPACE_INC =
		32'((64'(SPACE_HZ) << 32) / 64'(bfr_pkg::SAMPLE_HZ));
	localparam int unsigned TOP_HZ = (MARK_HZ > SPACE_HZ) ? MARK_HZ : SPACE_HZ;
	// tones above half the sample rate are never reported
	localparam bit NYQ_OK = bfr_pkg::SAMPLE_HZ >= 2 * TOP_HZ;
	localparam logic [8:0] SDIV_M1 = 9'(bfr_pkg::SAMPLE_DIV - 1);
	localparam logic [17:0] DDIV_M1 = 18'(DEC_DIV - 1);
	localparam logic [28:0] TMO_M1 = 29'(TIMEOUT_CYC - 1);
	localparam logic [5:0] FB_N = 6'(FB);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] abs32(input logic signed [31:0] v);
		return v[31] ? 32'(-v) : 32'(v);
	endfunction : abs32

	function automatic logic signed [31:0] corr_step(input logic signed [31:0] acc,
		input logic signed [ADC_W:0] x, input logic neg);
		return neg ? acc - 32'(x) : acc + 32'(x);
	endfunction : corr_step

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	bfr_pkg::bfr_state_t state_q;
	logic [ADC_W-1:0] adc_m_q;
	logic [ADC_W-1:0] adc_s_q;
	logic run_q;
	logic [7:0] thr_q;
	logic [8:0] samp_cnt_q;
	logic [17:0] dec_cnt_q;
	logic [28:0] tmo_cnt_q;
	logic [31:0] mark_ph_q;
	logic [31:0] space_ph_q;
	logic signed [31:0] mi_q;
	logic signed [31:0] mq_q;
	logic signed [31:0] si_q;
	logic signed [31:0] sq_q;
	logic [31:0] en_q;
	logic [1:0] run_len_q;
	logic last_tone_q;
	logic signed [1:0] bitbuf_q [FB];
	logic [5:0] bit_cnt_q;
	logic signed [5:0] wsum_q [NW];
	logic signed [7:0] pkt_sum_q;
	logic done_q;
	logic tmo_q;
	logic tmo_evt_q;
	logic samp_tick;
	logic dec_tick;
	logic buf_full;
	logic tmo_hit;
	logic signed [ADC_W:0] x_s;
	logic [32:0] mark_mag;
	logic [32:0] space_mag;
	logic [40:0] thr_prod;
	logic hit;
	logic tone;
	logic [1:0] run_len_d;
	logic append;
	logic signed [5:0] wsum_d [NW];
	logic signed [7:0] pkt_sum_d;
	logic st_wr;

	// ----------------------------------------------------------------
	// input synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			adc_m_q <= '0;
			adc_s_q <= '0;
		end else if (clk_en_i) begin
			adc_m_q <= adc_data_i;
			adc_s_q <= adc_m_q;
		end
	end

	// ----------------------------------------------------------------
	// tick and timeout generation
	// ----------------------------------------------------------------
	assign buf_full = bit_cnt_q == FB_N;
	assign samp_tick = clk_en_i && state_q == bfr_pkg::ST_RECV && samp_cnt_q == SDIV_M1;
	assign dec_tick = clk_en_i && state_q == bfr_pkg::ST_RECV && dec_cnt_q == DDIV_M1;
	assign tmo_hit = state_q == bfr_pkg::ST_RECV && tmo_cnt_q == TMO_M1;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			samp_cnt_q <= '0;
			dec_cnt_q <= '0;
			tmo_cnt_q <= '0;
		end else if (clk_en_i) begin
			// clear on the stopping edge too, so the timer reads zero once stopped
			if (state_q != bfr_pkg::ST_RECV || buf_full || tmo_hit) begin
				samp_cnt_q <= '0;
				dec_cnt_q <= '0;
				tmo_cnt_q <= '0;
			end else begin
				samp_cnt_q <= samp_tick ? 9'h000 : samp_cnt_q + 9'h001;
				dec_cnt_q <= dec_tick ? 18'h0_0000 : dec_cnt_q + 18'h0_0001;
				tmo_cnt_q <= tmo_cnt_q + 29'h0000_0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// correlator
	// ----------------------------------------------------------------
	// remove mid-scale offset
	assign x_s = $signed({1'b0, adc_s_q}) - $signed({2'b01, {(ADC_W - 1){1'b0}}});

	// square-wave references in phase and quadrature
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			mark_ph_q <= '0;
			space_ph_q <= '0;
			mi_q <= '0;
			mq_q <= '0;
			si_q <= '0;
			sq_q <= '0;
			en_q <= '0;
		end else if (clk_en_i) begin
			if (state_q != bfr_pkg::ST_RECV || dec_tick) begin
				mi_q <= '0;
				mq_q <= '0;
				si_q <= '0;
				sq_q <= '0;
				en_q <= '0;
			end else if (samp_tick) begin
				mark_ph_q <= mark_ph_q + MARK_INC;
				space_ph_q <= space_ph_q + SPACE_INC;
				mi_q <= corr_step(mi_q, x_s, mark_ph_q[31]);
				mq_q <= corr_step(mq_q, x_s, mark_ph_q[31] ^ mark_ph_q[30]);
				si_q <= corr_step(si_q, x_s, space_ph_q[31]);
				sq_q <= corr_step(sq_q, x_s, space_ph_q[31] ^ space_ph_q[30]);
				en_q <= en_q + abs32(32'(x_s));
			end
		end
	end

	// ----------------------------------------------------------------
	// tone decision
	// ----------------------------------------------------------------
	assign mark_mag = 33'(abs32(mi_q)) + 33'(abs32(mq_q));
	assign space_mag = 33'(abs32(si_q)) + 33'(abs32(sq_q));
	assign tone = mark_mag >= space_mag;
	// threshold is an 8-bit fraction, always in [0, 1)
	assign thr_prod = 41'(en_q) * 41'(thr_q);
	// larger magnitude, normalised by energy, must beat the threshold
	assign hit = NYQ_OK && ({tone ? mark_mag : space_mag, 8'h00} > thr_prod);

	// a bit needs two decision ticks of one tone; the third resets
	always_comb begin
		run_len_d = 2'd0;
		if (hit) begin
			run_len_d = (tone == last_tone_q && run_len_q != 2'd0) ? run_len_q + 2'd1 : 2'd1;
		end
		if (run_len_d == 2'd3) begin
			run_len_d = 2'd0;
		end
	end

	assign append = dec_tick && hit && run_len_d == 2'd2 && !buf_full;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			run_len_q <= '0;
			last_tone_q <= 1'b0;
		end else if (clk_en_i) begin
			if (state_q != bfr_pkg::ST_RECV) begin
				run_len_q <= '0;
			end else if (dec_tick) begin
				run_len_q <= run_len_d;
				last_tone_q <= tone;
			end
		end
	end

	// ----------------------------------------------------------------
	// bit buffer
	// ----------------------------------------------------------------
	// thirty-three signed entries, cleared after packetizing
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			bit_cnt_q <= '0;
			for (int i = 0; i < FB; i++) begin
				bitbuf_q[i] <= '0;
			end
		end else if (clk_en_i) begin
			if (state_q == bfr_pkg::ST_PACK) begin
				bit_cnt_q <= '0;
				for (int i = 0; i < FB; i++) begin
					bitbuf_q[i] <= '0;
				end
			end else if (append) begin
				bitbuf_q[bit_cnt_q] <= tone ? 2'sd1 : -2'sd1;
				bit_cnt_q <= bit_cnt_q + 6'd1;
			end
		end
	end

	// ----------------------------------------------------------------
	// packetizer
	// ----------------------------------------------------------------
	// word totals and packet total
	always_comb begin
		pkt_sum_d = '0;
		for (int w = 0; w < NW; w++) begin
			wsum_d[w] = '0;
			for (int b = 0; b < WL; b++) begin
				wsum_d[w] = wsum_d[w] + 6'(bitbuf_q[w * WL + b]);
			end
			pkt_sum_d = pkt_sum_d + 8'(wsum_d[w]);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			pkt_sum_q <= '0;
			for (int w = 0; w < NW; w++) begin
				wsum_q[w] <= '0;
			end
		end else if (clk_en_i && state_q == bfr_pkg::ST_PACK) begin
			pkt_sum_q <= pkt_sum_d;
			for (int w = 0; w < NW; w++) begin
				wsum_q[w] <= wsum_d[w];
			end
		end
	end

	// ----------------------------------------------------------------
	// control state machine
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			state_q <= bfr_pkg::ST_IDLE;
			tmo_evt_q <= 1'b0;
		end else if (clk_en_i) begin
			case (state_q)
				bfr_pkg::ST_IDLE: begin
					// path already open before reception starts
					if (run_q && rx_path_en_o) begin
						state_q <= bfr_pkg::ST_RECV;
					end
				end
				bfr_pkg::ST_RECV: begin
					if (buf_full) begin
						state_q <= bfr_pkg::ST_PACK;
						tmo_evt_q <= 1'b0;
					// no packet in time stops reception
					end else if (tmo_hit) begin
						state_q <= bfr_pkg::ST_IND;
						tmo_evt_q <= 1'b1;
					end
				end
				bfr_pkg::ST_PACK: begin
					state_q <= bfr_pkg::ST_IND;
				end
				bfr_pkg::ST_IND: begin
					// restart only once indication is issued
					state_q <= (run_q && rx_path_en_o) ? bfr_pkg::ST_RECV : bfr_pkg::ST_IDLE;
				end
				default: begin
					state_q <= bfr_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// indication
	// ----------------------------------------------------------------
	// one cycle pulse per indication
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			one_pkt_o <= 1'b0;
			zero_pkt_o <= 1'b0;
		end else if (clk_en_i) begin
			one_pkt_o <= 1'b0;
			zero_pkt_o <= 1'b0;
			if (state_q == bfr_pkg::ST_IND) begin
				one_pkt_o <= tmo_evt_q || pkt_sum_q != 8'(bfr_pkg::PKT_ZERO_SUM);
				zero_pkt_o <= tmo_evt_q || pkt_sum_q != 8'(bfr_pkg::PKT_ONE_SUM);
			end
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	assign st_wr = reg_wr_i && reg_addr_i == bfr_pkg::STATUS_OFS;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			run_q <= 1'b0;
			thr_q <= bfr_pkg::THRESH_RST;
			rx_path_en_o <= 1'b0;
		end else if (clk_en_i) begin
			// receive path follows the run bit
			rx_path_en_o <= run_q;
			if (reg_wr_i && reg_addr_i == bfr_pkg::CTRL_OFS) begin
				run_q <= reg_wdata_i[bfr_pkg::CTRL_RUN_BIT];
				thr_q <= reg_wdata_i[bfr_pkg::CTRL_THR_LSB +: 8];
			end
		end
	end

	// sticky flags, write one to clear, set wins
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			done_q <= 1'b0;
			tmo_q <= 1'b0;
		end else if (clk_en_i) begin
			if (state_q == bfr_pkg::ST_RECV && buf_full) begin
				done_q <= 1'b1;
			end else if (st_wr && reg_wdata_i[bfr_pkg::ST_DONE_BIT]) begin
				done_q <= 1'b0;
			end
			if (state_q == bfr_pkg::ST_RECV && !buf_full && tmo_hit) begin
				tmo_q <= 1'b1;
			end else if (st_wr && reg_wdata_i[bfr_pkg::ST_TMO_BIT]) begin
				tmo_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			reg_rdata_o <= 32'h0000_0000;
		end else if (clk_en_i) begin
			reg_rdata_o <= 32'h0000_0000;
			if (reg_rd_i && reg_addr_i == bfr_pkg::CTRL_OFS) begin
				reg_rdata_o[bfr_pkg::CTRL_RUN_BIT] <= run_q;
				reg_rdata_o[bfr_pkg::CTRL_THR_LSB +: 8] <= thr_q;
			end else if (reg_rd_i && reg_addr_i == bfr_pkg::STATUS_OFS) begin
				reg_rdata_o[bfr_pkg::ST_DONE_BIT] <= done_q;
				reg_rdata_o[bfr_pkg::ST_TMO_BIT] <= tmo_q;
				reg_rdata_o[bfr_pkg::ST_ONE_BIT] <= pkt_sum_q == 8'(bfr_pkg::PKT_ONE_SUM);
				reg_rdata_o[bfr_pkg::ST_ZERO_BIT] <= pkt_sum_q == 8'(bfr_pkg::PKT_ZERO_SUM);
				reg_rdata_o[bfr_pkg::ST_STATE_LSB +: 2] <= state_q;
				reg_rdata_o[bfr_pkg::ST_RXEN_BIT] <= rx_path_en_o;
				reg_rdata_o[bfr_pkg::ST_BITCNT_LSB +: 6] <= bit_cnt_q;
				for (int w = 0; w < NW; w++) begin
					reg_rdata_o[bfr_pkg::ST_W1_LSB + w] <= wsum_q[w] == 6'sd1;
					reg_rdata_o[bfr_pkg::ST_W0_LSB + w] <= wsum_q[w] == -6'sd1;
				end
			end else if (reg_rd_i && reg_addr_i == bfr_pkg::SUMS_OFS) begin
				reg_rdata_o[7:0] <= 8'(wsum_q[0]);
				reg_rdata_o[15:8] <= 8'(wsum_q[1]);
				reg_rdata_o[23:16] <= 8'(wsum_q[2]);
				reg_rdata_o[bfr_pkg::SUM_PKT_LSB +: 8] <= pkt_sum_q;
			end
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	path_open_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_q == bfr_pkg::ST_RECV |-> rx_path_en_o)
		else $error("receiving with path closed");
	samp_period_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		samp_tick |=> !samp_tick && samp_cnt_q == 9'h000)
		else $error("sample divider wrong");
	dec_period_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		dec_tick |=> dec_cnt_q == 18'h0_0000 && en_q == 32'h0000_0000)
		else $error("decision tick did not restart window");
	ticks_halt_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_q != bfr_pkg::ST_RECV |-> !samp_tick && !dec_tick && tmo_cnt_q == 29'h0000_0000)
		else $error("ticks or timer running while stopped");
	full_flag_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		clk_en_i && state_q == bfr_pkg::ST_RECV && buf_full
		|=> state_q == bfr_pkg::ST_PACK && done_q)
		else $error("full buffer not flagged");
	timeout_stop_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		clk_en_i && tmo_hit && !buf_full |=> state_q == bfr_pkg::ST_IND && tmo_q && tmo_evt_q)
		else $error("timeout did not stop reception");
	buf_clear_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		clk_en_i && state_q == bfr_pkg::ST_PACK
		|=> bit_cnt_q == 6'd0 && bitbuf_q[0] == 2'sd0 && bitbuf_q[FB - 1] == 2'sd0)
		else $error("buffer not cleared");
	tmo_both_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		clk_en_i && state_q == bfr_pkg::ST_IND && tmo_evt_q |=> one_pkt_o && zero_pkt_o)
		else $error("timeout did not pulse both");
	one_pkt_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		clk_en_i && state_q == bfr_pkg::ST_IND && !tmo_evt_q && pkt_sum_q == 8'sd3
		|=> one_pkt_o && !zero_pkt_o)
		else $error("one-packet misindicated");
	restart_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_q == bfr_pkg::ST_RECV && $past(state_q) != bfr_pkg::ST_RECV
		|-> $past(state_q) == bfr_pkg::ST_IND || $past(state_q) == bfr_pkg::ST_IDLE)
		else $error("reception restarted early");
	cov_packet_c: cover property (@(posedge ref_clk_i) disable iff (rst_i)
		state_q == bfr_pkg::ST_PACK);
	cov_timeout_c: cover property (@(posedge ref_clk_i) disable iff (rst_i)
		tmo_evt_q && one_pkt_o && zero_pkt_o);
	cov_zero_c: cover property (@(posedge ref_clk_i) disable iff (rst_i)
		zero_pkt_o && !one_pkt_o);

endmodule : bfr_receiver

`default_nettype wire

/* File: pkg/bfr_pkg.sv */
`default_nettype none

package bfr_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned MARK_HZ = 131_250;
	localparam int unsigned SPACE_HZ = 143_750;
	localparam int unsigned SAMPLE_HZ = 300_000;
	localparam int unsigned BIT_PERIOD_NS = 5_120_000;
	localparam int unsigned DEC_PER_BIT = 3;
	localparam int unsigned TIMEOUT_MS = 3000;
	// sample period is a longest time: round down
	localparam int unsigned SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;
	// decision period: nearest whole count to a third of a bit
	localparam int unsigned DEC_DIV = (BIT_PERIOD_NS + (DEC_PER_BIT * CLK_PERIOD_NS) / 2)
		/ (DEC_PER_BIT * CLK_PERIOD_NS);
	localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);

	// ----------------------------------------------------------------
	// frame format
	// ----------------------------------------------------------------
	localparam int unsigned WORD_LENGTH = 11;
	localparam int unsigned WORDS_PER_FRAME = 3;
	localparam int unsigned FRAME_BITS = WORD_LENGTH * WORDS_PER_FRAME;
	localparam int PKT_ONE_SUM = 3;
	localparam int PKT_ZERO_SUM = -3;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] SUMS_OFS = 8'h08;
	localparam int unsigned CTRL_RUN_BIT = 0;
	localparam int unsigned CTRL_THR_LSB = 8;
	localparam logic [7:0] THRESH_RST = 8'h1A;
	localparam int unsigned ST_DONE_BIT = 0;
	localparam int unsigned ST_TMO_BIT = 1;
	localparam int unsigned ST_ONE_BIT = 2;
	localparam int unsigned ST_ZERO_BIT = 3;
	localparam int unsigned ST_STATE_LSB = 4;
	localparam int unsigned ST_RXEN_BIT = 6;
	localparam int unsigned ST_BITCNT_LSB = 8;
	localparam int unsigned ST_W1_LSB = 16;
	localparam int unsigned ST_W0_LSB = 20;
	localparam int unsigned SUM_PKT_LSB = 24;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RECV = 2'b01,
		ST_PACK = 2'b10,
		ST_IND = 2'b11
	} bfr_state_t;

endpackage : bfr_pkg

`default_nettype wire

/* File: testbench/bfr_afe_model.sv */
`timescale 1ns/10ps
`default_nettype none

module bfr_afe_model #(
	parameter int unsigned MARK_HZ = bfr_pkg::MARK_HZ,
	parameter int unsigned SPACE_HZ = bfr_pkg::SPACE_HZ
) (
	// clock
	input wire logic ref_clk_i,
	// front end control from device and bench
	input wire logic path_en_i,
	input wire logic [1:0] tone_i,
	// sample towards the adc
	output logic [11:0] adc_data_o = 12'h800
);
	localparam logic [31:0] MARK_INC = 32'((64'(MARK_HZ) << 32) / bfr_pkg::CLK_HZ);
	localparam logic [31:0] SPACE_INC = 32'((64'(SPACE_HZ) << 32) / bfr_pkg::CLK_HZ);

	logic [31:0] phase_q = 32'h0000_0000;

	always_ff @(posedge ref_clk_i) begin
		case (tone_i)
			2'd1: phase_q <= phase_q + MARK_INC;
			2'd2: phase_q <= phase_q + SPACE_INC;
			default: phase_q <= phase_q;
		endcase
	end

	// closed receive path passes no signal
	always_ff @(posedge ref_clk_i) begin
		if (!path_en_i || tone_i == 2'd0 || tone_i == 2'd3) begin
			adc_data_o <= 12'h800;
		end else if (phase_q[31]) begin
			adc_data_o <= 12'hbe8;
		end else begin
			adc_data_o <= 12'h418;
		end
	end
endmodule : bfr_afe_model

`default_nettype wire

/* File: testbench/bfr_receiver_tb.sv */
`timescale 1ns/10ps
`default_nettype none

module bfr_receiver_tb;
	// short decision period holds four samples; tones one and two cycles per window
	localparam int unsigned DEC_DIV = 1333;
	localparam int unsigned TMO_CYC = 140_000;
	localparam int unsigned TB_MARK_HZ = 75_000;
	localparam int unsigned TB_SPACE_HZ = 150_000;
	localparam logic [10:0] CODE_WORD = 11'h5b8;

	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0000_0000;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [31:0] reg_rdata_o;
	logic rx_path_en_o;
	logic one_pkt_o;
	logic zero_pkt_o;
	logic [11:0] adc_data;
	logic [1:0] tone = 2'd0;
	logic [31:0] rd;
	realtime t_pkt;
	int unsigned n;
	int unsigned tmo;
	int error_cnt = 0;
	int checks_done = 0;

	always #(bfr_pkg::CLK_PERIOD_NS / 2) ref_clk_i = ~ref_clk_i;

	bfr_receiver #(.MARK_HZ(TB_MARK_HZ), .SPACE_HZ(TB_SPACE_HZ), .DEC_DIV(DEC_DIV),
		.TIMEOUT_CYC(TMO_CYC)) DUT (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .clk_en_i(1'b1), .adc_data_i(adc_data),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .rx_path_en_o(rx_path_en_o),
		.one_pkt_o(one_pkt_o), .zero_pkt_o(zero_pkt_o)
	);

	bfr_afe_model #(.MARK_HZ(TB_MARK_HZ), .SPACE_HZ(TB_SPACE_HZ)) afe (
		.ref_clk_i(ref_clk_i), .path_en_i(rx_path_en_o), .tone_i(tone), .adc_data_o(adc_data)
	);

	// ----------------------------------------------------------------
	// bus and check tasks
	// ----------------------------------------------------------------
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b0;
		#1;
		d = reg_rdata_o;
	endtask : reg_rd

	task automatic wait_ind(input int unsigned lim, output int unsigned cnt);
		cnt = 0;
		do begin
			@(posedge ref_clk_i);
			#1;
			cnt++;
		end while (one_pkt_o !== 1'b1 && zero_pkt_o !== 1'b1 && cnt < lim);
	endtask : wait_ind

	// each bit spans three decision periods, mark for one and space for zero
	task automatic send_word(input logic [10:0] w);
		for (int i = 0; i < 11; i++) begin
			@(posedge ref_clk_i);
			tone <= w[i] ? 2'd1 : 2'd2;
			repeat (3 * DEC_DIV - 1) @(posedge ref_clk_i);
		end
	endtask : send_word

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : final_report

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		reg_rd(bfr_pkg::CTRL_OFS, rd);
		chk("ctrl reset", 32'h0000_1a00, rd);
		reg_rd(bfr_pkg::STATUS_OFS, rd);
		chk("status reset", 32'h0000_0000, rd);
		chk("path enable reset", 32'h0000_0000, {31'h0, rx_path_en_o});
		reg_wr(8'h0c, 32'hffff_ffff);
		reg_rd(8'h0c, rd);
		chk("unmapped read", 32'h0000_0000, rd);
		reg_rd(bfr_pkg::CTRL_OFS, rd);
		chk("ctrl after unmapped write", 32'h0000_1a00, rd);
		$display("test reset and map done");

		reg_wr(bfr_pkg::CTRL_OFS, 32'h0000_1a01);
		@(posedge ref_clk_i);
		#1;
		chk("path enable on", 32'h0000_0001, {31'h0, rx_path_en_o});
		reg_rd(bfr_pkg::STATUS_OFS, rd);
		chk("status receiving", 32'h0000_0050, rd & 32'h0000_0070);
		$display("test start done");

		fork
			begin
				repeat (3) send_word(CODE_WORD);
				@(posedge ref_clk_i);
				tone <= 2'd0;
			end
			begin
				wait_ind(3 * 33 * DEC_DIV + 1000, n);
				t_pkt = $realtime;
				chk("packet pulses", 32'h0000_0002, {30'h0, one_pkt_o, zero_pkt_o});
				reg_rd(bfr_pkg::SUMS_OFS, rd);
				chk("sums", 32'h0301_0101, rd);
				reg_rd(bfr_pkg::STATUS_OFS, rd);
				chk("status packet", 32'h0007_0055, rd & 32'h0077_007f);
				$display("test one packet done");
				wait_ind(TMO_CYC + 1000, n);
				tmo = int'(($realtime - t_pkt) / bfr_pkg::CLK_PERIOD_NS);
				chk("timeout pulses", 32'h0000_0003, {30'h0, one_pkt_o, zero_pkt_o});
				chk("timeout span", 32'h0000_0001, {31'h0, tmo >= TMO_CYC && tmo <= TMO_CYC + 3});
			end
		join

		reg_rd(bfr_pkg::STATUS_OFS, rd);
		chk("status timeout", 32'h0000_0003, rd & 32'h0000_0003);
		reg_wr(bfr_pkg::STATUS_OFS, 32'h0000_0003);
		reg_rd(bfr_pkg::STATUS_OFS, rd);
		chk("status cleared", 32'h0000_0000, rd & 32'h0000_0003);
		reg_wr(bfr_pkg::CTRL_OFS, 32'h0000_1a00);
		@(posedge ref_clk_i);
		#1;
		chk("path enable off", 32'h0000_0000, {31'h0, rx_path_en_o});
		$display("test timeout and stop done");
		final_report();
	end

	initial begin
		#(800 * (3 * 33 * DEC_DIV + TMO_CYC) / 50);
		error_cnt++;
		$display("BAD watchdog expected finish seen hang");
		final_report();
	end
endmodule : bfr_receiver_tb

`default_nettype wire
